/* core/eeprom_serial_word_access.sv */
`timescale 1ns/1ps
`include "eeprom_cfg.svh"

module eeprom_serial_word_access #(
    parameter int unsigned PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS,
    parameter int unsigned FIFO_DEPTH  = `FIFO_DEPTH
) (
    // System side
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    output      logic busy_o,
    // Serial link
    input  wire logic link_clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output      logic sda_o,
    output      logic sda_oe_o
);
    if (PROG_CYCLES < 1) begin : g_bad_prog
        $error("PROG_CYCLES must be at least one");
    end

    localparam int RW = eeprom_pkg::ROW_W;
    localparam int WW = eeprom_pkg::WORD_W;

    // ****************************************************
    // Declarations
    // ****************************************************
    logic                    link_rst_m;
    logic                    link_rst_b;
    logic                    scl_m;
    logic                    scl_s;
    logic                    scl_p;
    logic                    sda_m;
    logic                    sda_s;
    logic                    sda_p;
    logic                    scl_rise;
    logic                    scl_fall;
    logic                    start_det;
    logic                    stop_det;
    logic                    ctrl_end;
    eeprom_pkg::link_state_t state;
    logic [3:0]              bitcnt;
    logic [7:0]              shift_in;
    logic [7:0]              shifter;
    logic [7:0]              ctrl_byte;
    logic [7:0]              first_half;
    logic [7:0]              other_half;
    logic [RW-1:0]           ctrl_row;
    logic [RW-1:0]           next_row;
    logic [1:0]              ctrl_mode;
    logic                    ctrl_rd;
    logic                    ctrl_ok;
    logic                    ctrl_recov;
    logic                    mode_ok;
    logic                    low_first;
    logic                    second;
    logic                    outstanding;
    logic [1:0]              nbytes;
    logic [WW-1:0]           word_buf;
    eeprom_pkg::req_t        req;
    logic                    req_tgl;
    logic                    rsp_m;
    logic                    rsp_s;
    logic                    rsp_seen;
    logic                    rsp_new;
    logic                    req_m;
    logic                    req_s;
    logic                    req_seen;
    logic                    rsp_tgl;
    logic [WW-1:0]           rsp_data;
    logic [31:0]             prog_cnt;
    logic [WW-1:0]           mem [eeprom_pkg::ROWS];
    logic [WW-1:0]           rd_word;
    eeprom_pkg::req_t        pop_req;
    logic                    pop_fire;

    word_if #(.WIDTH($bits(eeprom_pkg::req_t))) push_if ();
    word_if #(.WIDTH($bits(eeprom_pkg::req_t))) pop_if ();

    // ****************************************************
    // Link domain: reset, pin synchronisers, conditions
    // ****************************************************
    always_ff @(posedge link_clk_i) begin
        link_rst_m <= rst_b_i;
        link_rst_b <= link_rst_m;
    end

    always_ff @(posedge link_clk_i) begin
        scl_m <= scl_i;
        scl_s <= scl_m;
        scl_p <= scl_s;
        sda_m <= sda_i;
        sda_s <= sda_m;
        sda_p <= sda_s;
    end

    assign scl_rise   = scl_s && !scl_p;
    assign scl_fall   = !scl_s && scl_p;
    assign start_det  = scl_s && scl_p && sda_p && !sda_s;
    assign stop_det   = scl_s && scl_p && !sda_p && sda_s;
    assign ctrl_byte  = {shift_in[6:0], sda_s};
    assign ctrl_end   = (state == eeprom_pkg::st_ctrl) && scl_rise && (bitcnt == 4'h7)
                        && !start_det && !stop_det;
    assign mode_ok    = (ctrl_byte[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_LOW_FIRST)
                        || (ctrl_byte[`CTRL_MODE_MSB:`CTRL_MODE_LSB] == `MODE_HIGH_FIRST);
    assign low_first  = (ctrl_mode == `MODE_LOW_FIRST);
    assign first_half = low_first ? word_buf[7:0] : word_buf[15:8];
    assign other_half = low_first ? word_buf[15:8] : word_buf[7:0];
    // Five-bit arithmetic rolls over at both ends
    assign next_row   = low_first ? ctrl_row + 5'h01 : ctrl_row - 5'h01;
    assign rsp_new    = (rsp_s != rsp_seen);

    // ****************************************************
    // Link domain: protocol engine
    // ****************************************************
    always_ff @(posedge link_clk_i) begin
        if (!link_rst_b) begin
            state       <= eeprom_pkg::st_idle;
            bitcnt      <= 4'h0;
            shift_in    <= 8'h00;
            shifter     <= 8'h00;
            ctrl_row    <= '0;
            ctrl_mode   <= 2'h0;
            ctrl_rd     <= 1'b0;
            ctrl_ok     <= 1'b0;
            ctrl_recov  <= 1'b0;
            second      <= 1'b0;
            outstanding <= 1'b0;
            nbytes      <= 2'h0;
            word_buf    <= '0;
            req         <= '0;
            req_tgl     <= 1'b0;
            rsp_m       <= 1'b0;
            rsp_s       <= 1'b0;
            rsp_seen    <= 1'b0;
            sda_o       <= 1'b0;
            sda_oe_o    <= 1'b0;
        end else begin
            rsp_m <= rsp_tgl;
            rsp_s <= rsp_m;
            // Issues below come later, so a new request wins over this clear
            if (rsp_new) begin
                rsp_seen    <= rsp_s;
                outstanding <= 1'b0;
                if (!req.is_write) begin
                    word_buf <= rsp_data;
                end
            end
            if (stop_det) begin
                state    <= eeprom_pkg::st_idle;
                sda_oe_o <= 1'b0;
                // Programming starts only at stop, with the merged word
                if (ctrl_ok && !ctrl_rd && !ctrl_recov && nbytes != 2'h0) begin
                    req         <= '{is_write: 1'b1, row: ctrl_row, data: word_buf};
                    req_tgl     <= ~req_tgl;
                    outstanding <= 1'b1;
                end
            end else if (start_det) begin
                state    <= eeprom_pkg::st_ctrl;
                bitcnt   <= 4'h0;
                nbytes   <= 2'h0;
                ctrl_ok  <= 1'b0;
                sda_oe_o <= 1'b0;
            end else begin
                unique case (state)
                    eeprom_pkg::st_idle, eeprom_pkg::st_ignore: begin
                    end
                    eeprom_pkg::st_ctrl: begin
                        if (scl_rise) begin
                            shift_in <= ctrl_byte;
                            bitcnt   <= bitcnt + 4'h1;
                        end
                        if (ctrl_end) begin
                            ctrl_row   <= ctrl_byte[`CTRL_ROW_MSB:`CTRL_ROW_LSB];
                            ctrl_mode  <= ctrl_byte[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
                            ctrl_rd    <= ctrl_byte[`CTRL_DIR_BIT];
                            ctrl_recov <= (ctrl_byte == `RECOVERY_CTRL);
                            ctrl_ok    <= !outstanding && (mode_ok || ctrl_byte == `RECOVERY_CTRL);
                            if (!outstanding && mode_ok) begin
                                req         <= '{is_write: 1'b0,
                                                 row: ctrl_byte[`CTRL_ROW_MSB:`CTRL_ROW_LSB],
                                                 data: '0};
                                req_tgl     <= ~req_tgl;
                                outstanding <= 1'b1;
                            end
                        end
                        if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt   <= 4'h0;
                            sda_oe_o <= ctrl_ok;
                            state    <= ctrl_ok ? eeprom_pkg::st_cack : eeprom_pkg::st_ignore;
                        end
                    end
                    eeprom_pkg::st_cack: begin
                        if (scl_fall) begin
                            if (ctrl_recov) begin
                                sda_oe_o <= 1'b0;
                                state    <= eeprom_pkg::st_ignore;
                            end else if (ctrl_rd) begin
                                sda_oe_o <= !first_half[7];
                                shifter  <= {first_half[6:0], 1'b0};
                                bitcnt   <= 4'h1;
                                second   <= 1'b0;
                                state    <= eeprom_pkg::st_tx;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state    <= eeprom_pkg::st_rx;
                            end
                        end
                    end
                    eeprom_pkg::st_tx: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                sda_oe_o <= 1'b0;
                                state    <= eeprom_pkg::st_tx_ack;
                            end else begin
                                sda_oe_o <= !shifter[7];
                                shifter  <= {shifter[6:0], 1'b0};
                                bitcnt   <= bitcnt + 4'h1;
                            end
                        end
                    end
                    eeprom_pkg::st_tx_ack: begin
                        if (scl_rise && sda_s) begin
                            state <= eeprom_pkg::st_ignore;
                        end else if (scl_fall) begin
                            // acknowledged, so the next byte follows
                            bitcnt <= 4'h1;
                            second <= !second;
                            state  <= eeprom_pkg::st_tx;
                            if (!second) begin
                                sda_oe_o    <= !other_half[7];
                                shifter     <= {other_half[6:0], 1'b0};
                                // Buffer is free once the second half sits in the shifter
                                ctrl_row    <= next_row;
                                req         <= '{is_write: 1'b0, row: next_row, data: '0};
                                req_tgl     <= ~req_tgl;
                                outstanding <= 1'b1;
                            end else begin
                                sda_oe_o <= !first_half[7];
                                shifter  <= {first_half[6:0], 1'b0};
                            end
                        end
                    end
                    eeprom_pkg::st_rx: begin
                        if (scl_rise) begin
                            shift_in <= ctrl_byte;
                            bitcnt   <= bitcnt + 4'h1;
                        end
                        if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (nbytes == 2'h2) begin
                                state <= eeprom_pkg::st_ignore;
                            end else begin
                                if ((nbytes == 2'h0) == low_first) begin
                                    word_buf[7:0] <= shift_in;
                                end else begin
                                    word_buf[15:8] <= shift_in;
                                end
                                nbytes   <= nbytes + 2'h1;
                                sda_oe_o <= 1'b1;
                                state    <= eeprom_pkg::st_rx_ack;
                            end
                        end
                    end
                    eeprom_pkg::st_rx_ack: begin
                        if (scl_fall) begin
                            sda_oe_o <= 1'b0;
                            state    <= eeprom_pkg::st_rx;
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************
    // System domain: request crossing and buffering
    // ****************************************************
    // Request payload stays still until its answer returns
    assign push_if.valid = (req_s != req_seen);
    assign push_if.data  = req;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            req_m    <= 1'b0;
            req_s    <= 1'b0;
            req_seen <= 1'b0;
        end else begin
            req_m <= req_tgl;
            req_s <= req_m;
            if (push_if.valid && push_if.ready) begin
                req_seen <= req_s;
            end
        end
    end

    word_fifo #(
        .WIDTH ($bits(eeprom_pkg::req_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .in_if   (push_if),
        .out_if  (pop_if)
    );

    // ****************************************************
    // System domain: word array and programming
    // ****************************************************
    // Draining stalls while a word is programming
    assign pop_if.ready = (prog_cnt == 32'h0);
    assign pop_req      = pop_if.data;
    assign pop_fire     = pop_if.valid && pop_if.ready;
    assign rd_word      = mem[pop_req.row];

    for (genvar i = 0; i < eeprom_pkg::ROWS; i++) begin : g_row
        localparam logic [RW-1:0] IDX = RW'(i);
        always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
                mem[i] <= `MEM_RESET;
            end else if (pop_fire && pop_req.is_write && pop_req.row == IDX) begin
                mem[i] <= pop_req.data;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rsp_tgl  <= 1'b0;
            rsp_data <= '0;
            prog_cnt <= 32'h0;
            busy_o   <= 1'b0;
        end else begin
            busy_o <= (prog_cnt != 32'h0);
            if (pop_fire && !pop_req.is_write) begin
                rsp_data <= rd_word;
                rsp_tgl  <= ~rsp_tgl;
            end else if (pop_fire) begin
                prog_cnt <= 32'(PROG_CYCLES);
            end else if (prog_cnt != 32'h0) begin
                prog_cnt <= prog_cnt - 32'h1;
                if (prog_cnt == 32'h1) begin
                    rsp_tgl <= ~rsp_tgl;
                end
            end
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    property p_start;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        start_det |=> (state == eeprom_pkg::st_ctrl) && !sda_oe_o;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        stop_det |=> (state == eeprom_pkg::st_idle) && !sda_oe_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");

    property p_decode;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        ctrl_end |=> (ctrl_row == $past(ctrl_byte[7:3])) && (ctrl_rd == $past(ctrl_byte[0]));
    endproperty
    a_decode: assert property (p_decode) else $error("control byte misdecoded");

    property p_busy_nack;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        ctrl_end && outstanding |=> !ctrl_ok;
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");

    property p_step;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        (state == eeprom_pkg::st_tx_ack) && scl_fall && !second && !start_det && !stop_det
        |=> outstanding && (ctrl_row == ($past(low_first) ? 5'($past(ctrl_row) + 5'h01)
                                                         : 5'($past(ctrl_row) - 5'h01)));
    endproperty
    a_step: assert property (p_step) else $error("row step wrong");

    sequence s_rx_first;
        (state == eeprom_pkg::st_rx) && scl_fall && (bitcnt == 4'h8) && (nbytes == 2'h0)
        && !start_det && !stop_det && !rsp_new;
    endsequence

    property p_rx_low;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        s_rx_first and low_first |=> (word_buf[7:0] == $past(shift_in)) && sda_oe_o;
    endproperty
    a_rx_low: assert property (p_rx_low) else $error("first byte not low");

    property p_rx_high;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        s_rx_first and !low_first |=> (word_buf[15:8] == $past(shift_in)) && sda_oe_o;
    endproperty
    a_rx_high: assert property (p_rx_high) else $error("first byte not high");

    property p_tx_first;
        @(posedge link_clk_i) disable iff (!link_rst_b)
        (state == eeprom_pkg::st_cack) && scl_fall && ctrl_rd && !ctrl_recov
        && !start_det && !stop_det
        |=> (sda_oe_o == !$past(first_half[7])) && (shifter[7:1] == $past(first_half[6:0]));
    endproperty
    a_tx_first: assert property (p_tx_first) else $error("wrong first byte");

    sequence s_write_pop;
        pop_fire && pop_req.is_write;
    endsequence

    property p_prog;
        @(posedge clk_i) disable iff (!rst_b_i)
        s_write_pop |=> (prog_cnt == 32'(PROG_CYCLES)) && !pop_if.ready;
    endproperty
    a_prog: assert property (p_prog) else $error("programming not held");

    property p_read_rsp;
        @(posedge clk_i) disable iff (!rst_b_i)
        pop_fire && !pop_req.is_write
        |=> (rsp_data == $past(rd_word)) && (rsp_tgl != $past(rsp_tgl));
    endproperty
    a_read_rsp: assert property (p_read_rsp) else $error("word not loaded");
endmodule : eeprom_serial_word_access

/* core/eeprom_cfg.svh */
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

// ****************************************************
// Timing
// ****************************************************
`define CLK_PERIOD_NS   100
`define PROG_TIME_NS    10000000

// ****************************************************
// Control byte layout and codes
// ****************************************************
`define CTRL_ROW_MSB    7
`define CTRL_ROW_LSB    3
`define CTRL_MODE_MSB   2
`define CTRL_MODE_LSB   1
`define CTRL_DIR_BIT    0
`define MODE_LOW_FIRST  2'h1
`define MODE_HIGH_FIRST 2'h2
`define RECOVERY_CTRL   8'hFF

// ****************************************************
// Reset values and sizes
// ****************************************************
`define MEM_RESET       16'h0000
`define FIFO_DEPTH      16

`endif

/* core/eeprom_pkg.sv */
package eeprom_pkg;

    localparam int ROW_W  = 5;
    localparam int WORD_W = 16;
    localparam int ROWS   = 2 ** ROW_W;

    typedef enum logic [2:0] {
        st_idle,
        st_ctrl,
        st_cack,
        st_tx,
        st_tx_ack,
        st_rx,
        st_rx_ack,
        st_ignore
    } link_state_t;

    // One request from the link side to the array side
    typedef struct packed {
        logic              is_write;
        logic [ROW_W-1:0]  row;
        logic [WORD_W-1:0] data;
    } req_t;

endpackage : eeprom_pkg

/* core/word_if.sv */
`timescale 1ns/1ps

interface word_if #(
    parameter int WIDTH = 8
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : word_if

/* core/word_fifo.sv */
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // Fill and drain sides
    word_if.snk       in_if,
    word_if.src       out_if
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("word_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign full         = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty        = (wr_ptr == rd_ptr);
    assign in_if.ready  = !full;
    assign out_if.valid = !empty;
    assign out_if.data  = store[rd_ptr[AW-1:0]];
    assign push         = in_if.valid && !full;
    assign pop          = out_if.ready && !empty;

    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr[AW-1:0]] <= in_if.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : word_fifo

/* verification/mst.sv */
`timescale 1ns/1ps
// Bus master model: SCL rests high and SDA is released between frames
module mst (
    // A 1 on an output means released
    input  wire logic clk_i,
    input  wire logic sda_i,
    output      logic scl_o = 1'b1,
    output      logic sda_o = 1'b1
);
    // Data moves 4 cycles into the low phase, clear of the device's hold
    task automatic bit_io(input logic b, output logic s);
        repeat (4) @(negedge clk_i);
        sda_o = b;
        repeat (12) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (12) @(negedge clk_i);
        s = sda_i;
        scl_o = 1'b0;
    endtask : bit_io
    task automatic start();
        repeat (12) @(negedge clk_i);
        sda_o = 1'b0;
        repeat (12) @(negedge clk_i);
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        repeat (4) @(negedge clk_i);
        sda_o = 1'b0;
        repeat (12) @(negedge clk_i);
        scl_o = 1'b1;
        repeat (12) @(negedge clk_i);
        sda_o = 1'b1;
    endtask : stop
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, n);
    endtask : xfer
endmodule : mst

/* verification/eeprom_serial_word_access_test.sv */
`timescale 1ns/1ps
module eeprom_serial_word_access_test;
    logic       clk_i    = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst_b    = 1'b0;
    logic       busy, scl, sda_m, sda_d, sda_oe, n;
    logic [7:0] rd;
    int         error_cnt   = 0;
    int         check_count = 0;
    // Open drain wire with pull-up
    wire        sda = sda_m & (~sda_oe | sda_d);
    eeprom_serial_word_access #(.PROG_CYCLES(400)) eeprom_serial_word_access_i (
        .clk_i(clk_i), .rst_b_i(rst_b), .busy_o(busy), .link_clk_i(link_clk),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe));
    mst mst_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    initial forever #50 clk_i = ~clk_i;
    initial #3 forever #6 link_clk = ~link_clk;
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic ctrl(input logic [7:0] c, input logic ack);
        mst_i.start();
        mst_i.xfer(c, 1'b1, rd, n);
        check("control ack", {7'h00, n}, {7'h00, ~ack});
    endtask : ctrl
    task automatic wr_word(input logic [7:0] c, input logic [7:0] b0, input logic [7:0] b1);
        ctrl(c, 1'b1);
        mst_i.xfer(b0, 1'b1, rd, n);
        check("first data ack", {7'h00, n}, 8'h00);
        mst_i.xfer(b1, 1'b1, rd, n);
        check("data ack", {7'h00, n}, 8'h00);
        mst_i.stop();
        repeat (20) @(negedge clk_i);
        check("busy", {7'h00, busy}, 8'h01);
        ctrl(c, 1'b0);
        mst_i.stop();
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk_i);
    endtask : wr_word
    task automatic rd_seq(input logic [7:0] c, input logic [31:0] exp);
        ctrl(c, 1'b1);
        for (int i = 3; i >= 0; i--) begin
            mst_i.xfer(8'hFF, i == 0, rd, n);
            check("read byte", rd, exp[i*8 +: 8]);
        end
        mst_i.stop();
    endtask : rd_seq
    task automatic wr_one(input logic [7:0] c, input logic [7:0] b, input logic [31:0] exp);
        ctrl(c, 1'b1);
        mst_i.xfer(b, 1'b1, rd, n);
        check("single data ack", {7'h00, n}, 8'h00);
        mst_i.stop();
        for (int i = 0; i < 100 && busy !== 1'b1; i++) @(negedge clk_i);
        check("single busy", {7'h00, busy}, 8'h01);
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clk_i);
        rd_seq(c | 8'h01, exp);
    endtask : wr_one
    initial begin
        repeat (10) @(negedge clk_i);
        rst_b = 1'b1;
        repeat (10) @(negedge clk_i);
        ctrl(8'hFF, 1'b1);
        mst_i.stop();
        ctrl(8'h07, 1'b0);
        mst_i.stop();
        wr_word(8'hFA, 8'h34, 8'h12);
        wr_word(8'h04, 8'hAB, 8'hCD);
        rd_seq(8'hFB, 32'h3412CDAB);
        rd_seq(8'h05, 32'hABCD1234);
        wr_one(8'hFC, 8'h77, 32'h77340000);
        print_verdict();
    end
endmodule : eeprom_serial_word_access_test
